/* File: hdl/tpsm_pkg.sv */
// Package of constants and carrier types for the trace packet stream merger.
package tpsm_pkg;

  // Header byte encodings and category fields.
  localparam logic [7:0] SYNC_HDR       = 8'h00;  // Synchronization header and filler byte.
  localparam logic [7:0] SYNC_LAST      = 8'h80;  // Last sync byte, single one bit at the MSB.
  localparam logic [7:0] OVF_HDR        = 8'h70;  // Overflow header, no payload.
  localparam logic [7:0] LTS_HDR        = 8'hC0;  // Local timestamp header, multi-byte form.
  localparam logic [7:0] GTS_HDR        = 8'h94;  // Global timestamp header.
  localparam logic [7:0] PC_SAMPLE_HDR  = 8'h17;  // Profiling source header, four bytes payload.
  localparam logic [7:0] EVT_CNT_HDR    = 8'h05;  // Event counter source header, one byte.
  localparam logic [1:0] SRC_SIZE_1     = 2'h1;   // Source size code: one payload byte.
  localparam logic [1:0] SRC_SIZE_2     = 2'h2;   // Source size code: two payload bytes.
  localparam logic [1:0] SRC_SIZE_4     = 2'h3;   // Source size code: four payload bytes.
  localparam int         CONT_BIT       = 7;      // Continuation bit position.
  localparam int         SYNC_MIN_BYTES = 6;      // Least payload bytes after a sync header.
  localparam int         SYNC_PAY_BYTES = 6;      // Payload bytes this block sends.
  localparam int         MAX_PAYLOAD    = 4;      // Most payload bytes of other packets.
  localparam int         FIFO_DEPTH     = 32;     // Output FIFO depth in bytes.

  // Packet source priorities, lowest index wins.
  typedef enum logic [4:0] {
    SRC_NONE  = 5'h00,
    SRC_SYNC  = 5'h01,
    SRC_OVF   = 5'h02,
    SRC_PROF  = 5'h04,
    SRC_STIM  = 5'h08,
    SRC_TS    = 5'h10
  } tpsm_src_type;

  // A packet request from one source.
  typedef struct packed {
    logic        valid;    // Request pending.
    logic [1:0]  size;     // Source size code, or 0 for header only.
    logic [7:0]  header;   // Header byte.
    logic [31:0] payload;  // Payload, low byte sent first.
  } tpsm_pkt_type;

  // Merger state machine.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HDR  = 3'b010,
    ST_PAY  = 3'b100
  } tpsm_state_type;

endpackage

/* File: hdl/tpsm_fifo.sv */
// Byte FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module tpsm_fifo #(
  parameter int WIDTH = 8,                 // Word width.
  parameter int DEPTH = tpsm_pkg::FIFO_DEPTH  // Number of words, a power of two.
) (
  input  wire logic             clk_sys,   // System clock.
  input  wire logic             rst,       // Synchronous reset, active high.
  input  wire logic             in_valid,  // Write request.
  output logic                  in_ready,  // Space available.
  input  wire logic [WIDTH-1:0] in_data,   // Write data.
  output logic                  out_valid, // Data available.
  input  wire logic             out_ready, // Reader takes data.
  output logic      [WIDTH-1:0] out_data   // Read data, registered.
);
  localparam int AW = $clog2(DEPTH);

  // Reject depths the pointer arithmetic cannot serve.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("tpsm_fifo depth must be a power of two of at least 2");
  end

  // Pointers and output register of the FIFO in one struct; the storage array is separate.
  typedef struct packed {
    logic [AW:0]      wr;    // Write pointer with wrap bit.
    logic [AW:0]      rd;    // Read pointer with wrap bit.
    logic             ov;    // Output register holds a word.
    logic [WIDTH-1:0] od;    // Output register.
  } tpsm_fifo_st_type;

  tpsm_fifo_st_type s_q;       // Registered state.
  tpsm_fifo_st_type s_d;       // Next state.
  logic [WIDTH-1:0] mem [DEPTH];  // Storage array.
  logic             empty;     // Array empty.
  logic             full;      // Array full.
  logic             take;      // Move a word from array to output register.
  logic             push;      // Write this cycle.

  assign empty     = s_q.wr == s_q.rd;
  assign full      = (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]) && (s_q.wr[AW] != s_q.rd[AW]);
  assign in_ready  = !full;
  assign push      = in_valid && !full;
  assign take      = !empty && (!s_q.ov || out_ready);
  assign out_valid = s_q.ov;
  assign out_data  = s_q.od;

  // Next state: pointers move on push and take; output register refills.
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (take) begin
      s_d.rd = s_q.rd + 1'b1;
      s_d.od = mem[s_q.rd[AW-1:0]];
      s_d.ov = 1'b1;
    end else if (out_ready) begin
      s_d.ov = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage writes carry no reset; contents are don't-care until written.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[s_q.wr[AW-1:0]] <= in_data;
    end
  end

endmodule // tpsm_fifo

/* File: hdl/tpsm_merger.sv */
// Trace packet stream merger: formats and merges trace packets into one byte stream.
`timescale 1ns/1ps
module tpsm_merger #(
  parameter int PRESCALE = 64  // Post-scaler timer reload in clock cycles.
) (
  input  wire logic        clk_sys,          // System clock, 125 MHz.
  input  wire logic        rst,              // Synchronous reset, active high.
  input  wire logic        stim_wr,          // Software stimulus write, one-cycle pulse.
  input  wire logic [1:0]  stim_size,        // Stimulus size code, 1, 2 or 3 for 1/2/4 bytes.
  input  wire logic [4:0]  stim_port,        // Stimulus port number.
  input  wire logic [31:0] stim_data,        // Stimulus data.
  output logic             stim_busy,        // Stimulus slot full; a write now overflows.
  input  wire logic        prof_valid,       // Profiling unit packet offered.
  input  wire logic [7:0]  prof_header,      // Profiling unit packet header.
  input  wire logic [31:0] prof_payload,     // Profiling unit payload.
  output logic             prof_ready,       // Profiling packet accepted this cycle.
  input  wire logic        data_trace_evt,   // Data trace event, one-cycle pulse.
  input  wire logic [31:0] data_trace_val,   // Value carried by the data trace event.
  input  wire logic        counter_wrap,     // A profile counter wrapped, pulse.
  input  wire logic [31:0] pc_value,         // Current program counter.
  input  wire logic        pc_sample_enable, // Timer drives PC sample packets.
  input  wire logic        cycle_event_enable, // Timer drives event counter packets while pc_sample_enable is low.
  input  wire logic        sync_req,         // Request a synchronization packet, pulse.
  input  wire logic        gts_req,          // Request a global timestamp, pulse.
  input  wire logic [27:0] gts_value,        // Global timestamp value.
  input  wire logic        lts_enable,       // Emit a local timestamp after each run of source packets.
  output logic             out_valid,        // Output byte valid.
  input  wire logic        out_ready,        // Sink takes the byte.
  output logic [7:0]       out_byte,         // Output byte, registered.
  output logic             ser_bit,          // Serial stream, LSB first, registered.
  output logic             ser_valid         // Serial bit valid, registered.
);

  // Elaboration check on the timer reload.
  if (PRESCALE < 1 || PRESCALE > 65535) begin : g_bad_prescale
    $error("tpsm_merger PRESCALE must be 1..65535");
  end

  // All merger state in one struct.
  typedef struct packed {
    tpsm_pkg::tpsm_state_type st;     // Framer state.
    logic [7:0]               hdr;    // Header of packet being sent.
    logic [47:0]              pay;    // Payload shift register, low byte next.
    logic [2:0]               left;   // Payload bytes still to send.
    logic                     proto;  // Packet is protocol category.
    tpsm_pkg::tpsm_pkt_type   stim;   // Held stimulus packet.
    tpsm_pkg::tpsm_pkt_type   prof;   // Held profiling packet, own or forwarded.
    logic                     sync_p; // Sync pending.
    logic                     ovf_p;  // Overflow pending.
    logic                     gts_p;  // Global timestamp pending.
    logic                     lts_p;  // Local timestamp pending.
    logic [27:0]              ts;     // Local timestamp counter.
    logic [15:0]              post;   // Post-scaler timer.
    logic [7:0]               evcnt;  // Event count for counter packets.
    logic [7:0]               sh;     // Serializer shift byte.
    logic [3:0]               sbits;  // Serializer bits remaining.
  } tpsm_st_type;

  tpsm_st_type s_q;        // Registered state.
  tpsm_st_type s_d;        // Next state.
  logic        f_valid;    // Byte into FIFO.
  logic        f_ready;    // FIFO has room; stalls the framer.
  logic [7:0]  f_data;     // Byte written to FIFO.
  logic        q_valid;    // FIFO head valid.
  logic        q_take;     // Head consumed when the sink is ready and the serializer idle.
  logic [7:0]  q_data;     // FIFO head byte.
  logic        tick;       // Post-scaler expiry, one-cycle enable.

  // Bytes queue here so a stalled sink backs pressure into the framer.
  tpsm_fifo #(
    .WIDTH (8),
    .DEPTH (tpsm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (q_valid),
    .out_ready (q_take),
    .out_data  (q_data)
  );

  // Parallel and serial views use the same bytes, so the encoding does not depend on the sink.
  assign out_valid = q_valid;
  assign out_byte  = q_data;
  assign q_take    = q_valid && out_ready && (s_q.sbits == 4'h0);
  assign ser_bit   = s_q.sh[0];
  assign ser_valid = s_q.sbits != 4'h0;
  assign stim_busy = s_q.stim.valid;
  assign prof_ready = !s_q.prof.valid && !(tick && pc_sample_enable) && !data_trace_evt
                      && !counter_wrap && !(tick && cycle_event_enable);
  assign tick      = (s_q.post == 16'h0000) && (pc_sample_enable || cycle_event_enable);

  // Framer byte: header in the header state, low payload byte after it.
  assign f_valid = s_q.st != tpsm_pkg::ST_IDLE;
  always_comb begin
    if (s_q.st == tpsm_pkg::ST_HDR) begin
      f_data = s_q.hdr;
    end else begin
      f_data = s_q.pay[7:0];
    end
  end

  // Next-state logic: event capture, timer, arbitration and byte sequencing.
  always_comb begin
    s_d = s_q;
    // Taken flags drop here; later sets in this cycle win.
    if (s_q.st == tpsm_pkg::ST_IDLE) begin
      s_d.sync_p = 1'b0;
      s_d.ovf_p  = s_q.ovf_p && s_q.sync_p;
      s_d.gts_p  = s_q.gts_p && (s_q.sync_p || s_q.ovf_p || s_q.prof.valid || s_q.stim.valid);
    end
    // Local timestamp counter saturates-free wrap raises overflow.
    s_d.ts = s_q.ts + 28'h0000001;
    if (s_q.ts == 28'hFFFFFFF) begin
      s_d.ovf_p = 1'b1;
    end
    // Post-scaler timer reloads at expiry and only runs while enabled.
    if (!(pc_sample_enable || cycle_event_enable)) begin
      s_d.post = 16'(PRESCALE - 1);
    end else if (tick) begin
      s_d.post = 16'(PRESCALE - 1);
      s_d.evcnt = s_q.evcnt + 8'h01;
    end else begin
      s_d.post = s_q.post - 16'h0001;
    end
    // Profiling unit sources, own events first, then forwarded packets.
    if (!s_q.prof.valid) begin
      if (tick && pc_sample_enable) begin
        s_d.prof = '{1'b1, tpsm_pkg::SRC_SIZE_4, tpsm_pkg::PC_SAMPLE_HDR, pc_value};
      end else if (tick && cycle_event_enable) begin
        s_d.prof = '{1'b1, tpsm_pkg::SRC_SIZE_1, tpsm_pkg::EVT_CNT_HDR,
                     {24'h000000, s_q.evcnt}};
      end else if (data_trace_evt) begin
        s_d.prof = '{1'b1, tpsm_pkg::SRC_SIZE_4, 8'h47, data_trace_val};
      end else if (counter_wrap) begin
        s_d.prof = '{1'b1, tpsm_pkg::SRC_SIZE_1, tpsm_pkg::EVT_CNT_HDR,
                     {24'h000000, s_q.evcnt}};
      end else if (prof_valid) begin
        s_d.prof = '{1'b1, prof_header[1:0], prof_header, prof_payload};
      end
    end else if (data_trace_evt || counter_wrap || (tick && pc_sample_enable)
                 || (tick && cycle_event_enable)) begin
      s_d.ovf_p = 1'b1;
    end
    // Stimulus writes are held in one slot; a write to a full slot is an overflow.
    if (stim_wr) begin
      if (!s_q.stim.valid && stim_size != 2'h0) begin
        s_d.stim = '{1'b1, stim_size, {stim_port, 1'b0, stim_size}, stim_data};
      end else begin
        s_d.ovf_p = 1'b1;
      end
    end
    if (sync_req) begin
      s_d.sync_p = 1'b1;
    end
    if (gts_req) begin
      s_d.gts_p = 1'b1;
    end
    // Sequencing; a packet runs to its end before any other source is picked.
    unique case (s_q.st)
      tpsm_pkg::ST_IDLE: begin
        // Fixed priority: sync, overflow, profiling, stimulus, timestamps.
        if (s_q.sync_p) begin
          s_d.hdr    = tpsm_pkg::SYNC_HDR;
          s_d.pay    = {tpsm_pkg::SYNC_LAST, 40'h0000000000};
          s_d.left   = 3'(tpsm_pkg::SYNC_PAY_BYTES);
          s_d.proto  = 1'b0;
          s_d.st     = tpsm_pkg::ST_HDR;
        end else if (s_q.ovf_p) begin
          s_d.hdr   = tpsm_pkg::OVF_HDR;
          s_d.left  = 3'h0;
          s_d.proto = 1'b1;
          s_d.st    = tpsm_pkg::ST_HDR;
        end else if (s_q.prof.valid || s_q.stim.valid) begin
          if (s_q.prof.valid) begin
            s_d.hdr      = s_q.prof.header;
            s_d.pay      = {16'h0000, s_q.prof.payload};
            s_d.left     = (s_q.prof.size == tpsm_pkg::SRC_SIZE_4) ? 3'h4 : {1'b0, s_q.prof.size};
            s_d.prof     = '0;
          end else begin
            s_d.hdr      = s_q.stim.header;
            s_d.pay      = {16'h0000, s_q.stim.payload};
            s_d.left     = (s_q.stim.size == tpsm_pkg::SRC_SIZE_4) ? 3'h4 : {1'b0, s_q.stim.size};
            s_d.stim     = '0;
          end
          s_d.proto = 1'b0;
          s_d.lts_p = lts_enable;
          s_d.st    = tpsm_pkg::ST_HDR;
        end else if (s_q.gts_p) begin
          // Global timestamp, four payload bytes with continuation flags.
          s_d.hdr   = tpsm_pkg::GTS_HDR | 8'h80;
          s_d.pay   = {16'h0000, 1'b0, gts_value[27:21], 1'b1, gts_value[20:14],
                       1'b1, gts_value[13:7], 1'b1, gts_value[6:0]};
          s_d.left  = 3'h4;
          s_d.proto = 1'b1;
          s_d.st    = tpsm_pkg::ST_HDR;
        end else if (s_q.lts_p) begin
          // Local timestamp, delta since the last one, counter cleared.
          s_d.lts_p = 1'b0;
          s_d.ts    = 28'h0000000;
          s_d.hdr   = tpsm_pkg::LTS_HDR;
          s_d.pay   = {16'h0000, 1'b0, s_q.ts[27:21], 1'b1, s_q.ts[20:14],
                       1'b1, s_q.ts[13:7], 1'b1, s_q.ts[6:0]};
          s_d.left  = 3'(tpsm_pkg::MAX_PAYLOAD);
          s_d.proto = 1'b1;
          s_d.st    = tpsm_pkg::ST_HDR;
        end
      end
      tpsm_pkg::ST_HDR: begin
        if (f_ready) begin
          s_d.st = (s_q.left == 3'h0) ? tpsm_pkg::ST_IDLE : tpsm_pkg::ST_PAY;
        end
      end
      tpsm_pkg::ST_PAY: begin
        // Payload bytes shift out low byte first, in order.
        if (f_ready) begin
          s_d.pay  = {8'h00, s_q.pay[47:8]};
          s_d.left = s_q.left - 3'h1;
          if (s_q.left == 3'h1) begin
            s_d.st = tpsm_pkg::ST_IDLE;
          end
        end
      end
    endcase
    // Serializer loads a byte and shifts it out LSB first.
    if (q_valid && out_ready && s_q.sbits == 4'h0) begin
      s_d.sh    = q_data;
      s_d.sbits = 4'h8;
    end else if (s_q.sbits != 4'h0) begin
      s_d.sh    = {1'b0, s_q.sh[7:1]};
      s_d.sbits = s_q.sbits - 4'h1;
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q      <= '0;
      s_q.st   <= tpsm_pkg::ST_IDLE;
      s_q.post <= 16'(PRESCALE - 1);
    end else begin
      s_q <= s_d;
    end
  end

endmodule // tpsm_merger

/* File: tb/tpsm_merger_props.sv */
// Concurrent checks on the ports of the trace packet stream merger.
`timescale 1ns/1ps
module tpsm_merger_props #(
  parameter int PRESCALE = 64  // Timer reload; kept so the bind can pass it on.
) (
  input wire logic       clk_sys,            // System clock.
  input wire logic       rst,                // Synchronous reset, active high.
  input wire logic       stim_wr,            // Stimulus write pulse.
  input wire logic       stim_busy,          // Stimulus slot full.
  input wire logic       prof_ready,         // Profiling packet accepted.
  input wire logic       sync_req,           // Synchronization request pulse.
  input wire logic       pc_sample_enable,   // Timer makes PC samples.
  input wire logic       cycle_event_enable, // Timer makes event counts.
  input wire logic       out_valid,          // Output byte valid.
  input wire logic       out_ready,          // Sink takes the byte.
  input wire logic [7:0] out_byte,           // Output byte.
  input wire logic       ser_bit,            // Serial bit.
  input wire logic       ser_valid           // Serial bit valid.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [5:0] zero_run_q;  // Run of zero serial bits, saturating so it never wraps.

  // Counts zero bits in a row on the serial line; a one bit clears the run.
  always_ff @(posedge clk_sys) begin
    if (rst) zero_run_q <= 6'h00;
    else if (ser_valid) zero_run_q <= ser_bit ? 6'h00 : zero_run_q + {5'h00, zero_run_q != 6'h3F};
  end

  sequence sync_tail_s;  // A one bit after at least forty-seven zero bits.
    ser_valid && ser_bit && zero_run_q >= 6'h2F;
  endsequence
  sequence serial_burst_s;  // Eight serial bit times in a row.
    ser_valid [*8];
  endsequence

  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !out_valid && !ser_valid && !stim_busy)
    else $error("Output active right after reset.");
  hold_byte_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("Output byte changed before it was taken.");
  ser_burst_a: assert property ($rose(ser_valid) |-> serial_burst_s)
    else $error("Serial byte shorter than eight bits.");
  slot_fill_a: assert property (stim_wr && !stim_busy |=> stim_busy)
    else $error("Stimulus write not captured.");
  ovf_report_a: assert property (stim_wr && stim_busy |-> ##[1:300] (out_valid && out_byte == 8'h70))
    else $error("Refused write gave no overflow header.");
  sync_pattern_a: assert property (sync_req |-> ##[1:400] sync_tail_s)
    else $error("Synchronization pattern not seen.");
  ready_after_reset_a: assert property ($fell(rst) |-> prof_ready)
    else $error("Profiling input not ready after reset.");
  pc_sample_a: assert property (pc_sample_enable [*8] |-> ##[0:300]
    (out_valid && out_byte == tpsm_pkg::PC_SAMPLE_HDR))
    else $error("No PC sample header while sampling is enabled.");
  evt_count_a: assert property ((cycle_event_enable && !pc_sample_enable) [*8] |-> ##[0:300]
    (out_valid && out_byte == tpsm_pkg::EVT_CNT_HDR))
    else $error("No event counter header while counting is enabled.");
endmodule  // tpsm_merger_props

/* File: tb/tpsm_sink_model.sv */
// Trace sink model: paces out_ready and rebuilds bytes from the serial line.
`timescale 1ns/1ps
module tpsm_sink_model (
  input  wire logic clk_sys,   // System clock.
  input  wire logic rst,       // Synchronous reset, active high.
  input  wire logic stall,     // Slow mode: ready one cycle in three.
  input  wire logic ser_bit,   // Serial data, LSB first.
  input  wire logic ser_valid, // Serial bit valid.
  output logic      out_ready  // Sink takes the head byte.
);
  logic [7:0] sh_q;            // Bits gathered, newest at the top.
  logic [2:0] cnt_q;           // Bits gathered of the current byte.
  logic [1:0] ph_q = 2'h0;     // Pacing phase of slow mode.
  logic [7:0] rx_q[$];         // Bytes received, read by the testbench.

  initial out_ready = 1'b1;

  // Ready moves off the sampling edge so it never races the design.
  always @(negedge clk_sys) begin
    ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    out_ready <= !stall || ph_q == 2'h0;
  end

  // The first bit is the LSB, so each bit enters at the top and shifts down.
  always @(posedge clk_sys) begin
    if (rst) cnt_q <= 3'h0;
    else if (ser_valid) begin
      sh_q <= {ser_bit, sh_q[7:1]};
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h7) rx_q.push_back({ser_bit, sh_q[7:1]});
    end
  end
endmodule  // tpsm_sink_model

/* File: tb/test_tpsm_merger.sv */
// Self-checking testbench of the trace packet stream merger.
`timescale 1ns/1ps
module test_tpsm_merger;
  logic        clk_sys, rst, stall, stim_wr, stim_busy, prof_valid, prof_ready;
  logic        data_trace_evt, counter_wrap, pc_sample_enable, cycle_event_enable;
  logic        sync_req, gts_req, lts_enable, out_valid, out_ready, ser_bit, ser_valid;
  logic [1:0]  stim_size;
  logic [4:0]  stim_port;
  logic [7:0]  prof_header, out_byte, h;
  logic [27:0] gts_value;
  logic [31:0] stim_data, prof_payload, data_trace_val, pc_value;
  logic [7:0]  exp_q[$];   // Expected byte stream.
  logic [7:0]  pay[4];     // Payload of the last parsed packet.
  int          n_errors, checked, seed, cyc, n, k;

  tpsm_merger #(.PRESCALE(4)) tpsm_merger_i (
    .clk_sys(clk_sys), .rst(rst), .stim_wr(stim_wr), .stim_size(stim_size),
    .stim_port(stim_port), .stim_data(stim_data), .stim_busy(stim_busy),
    .prof_valid(prof_valid), .prof_header(prof_header), .prof_payload(prof_payload),
    .prof_ready(prof_ready), .data_trace_evt(data_trace_evt), .data_trace_val(data_trace_val),
    .counter_wrap(counter_wrap), .pc_value(pc_value), .pc_sample_enable(pc_sample_enable),
    .cycle_event_enable(cycle_event_enable), .sync_req(sync_req), .gts_req(gts_req),
    .gts_value(gts_value), .lts_enable(lts_enable), .out_valid(out_valid),
    .out_ready(out_ready), .out_byte(out_byte), .ser_bit(ser_bit), .ser_valid(ser_valid));
  tpsm_sink_model tpsm_sink_model_i (.clk_sys(clk_sys), .rst(rst), .stall(stall),
    .ser_bit(ser_bit), .ser_valid(ser_valid), .out_ready(out_ready));

  // The clock toggles every 4 ns, a period of 8 ns.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic int nb(logic [1:0] c);  // Payload bytes of a size code.
    return (c == 2'h3) ? 4 : int'(c);
  endfunction

  function automatic logic [7:0] take();  // An empty stream counts as a mismatch.
    if (tpsm_sink_model_i.rx_q.size() == 0) n_errors++;
    return (tpsm_sink_model_i.rx_q.size() == 0) ? 8'hFF : tpsm_sink_model_i.rx_q.pop_front();
  endfunction

  task automatic push_pay(logic [31:0] d, int cnt);  // Payload goes low byte first.
    for (int i = 0; i < cnt; i++) exp_q.push_back(d[8*i +: 8]);
  endtask

  task automatic push_sync();
    repeat (6) exp_q.push_back(8'h00);
    exp_q.push_back(8'h80);
  endtask

  // Waits until the stream has been quiet for twenty cycles, bounded.
  task automatic drain();
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 20; i++) begin
      @(negedge clk_sys);
      q = (out_valid || ser_valid) ? 0 : q + 1;
    end
    chk("drained", q >= 20, 1);
  endtask

  task automatic compare_all();
    drain();
    chk("byte count", tpsm_sink_model_i.rx_q.size(), exp_q.size());
    while (exp_q.size() > 0 && tpsm_sink_model_i.rx_q.size() > 0)
      chk("stream byte", take(), exp_q.pop_front());
    exp_q.delete();
    tpsm_sink_model_i.rx_q.delete();
  endtask

  // Splits one packet off the received stream by its header category.
  task automatic pop_pkt(output logic [7:0] hd, output int cnt);
    logic [7:0] b;
    cnt = 0;
    hd = take();
    b = hd;
    if (hd[1:0] != 2'h0) for (int i = 0; i < nb(hd[1:0]); i++) pay[i] = take();
    if (hd[1:0] != 2'h0) cnt = nb(hd[1:0]);
    else while (b[7] && cnt < 4) begin
      b = take();
      pay[cnt] = b;
      cnt++;
    end
  endtask

  // With refuse set the strobe stays up one more edge, into the full slot.
  task automatic stim(logic [4:0] port, logic [1:0] sz, logic [31:0] d, bit refuse);
    for (int i = 0; i < 200 && stim_busy; i++) @(negedge clk_sys);
    {stim_wr, stim_port, stim_size, stim_data} = {1'b1, port, sz, d};
    exp_q.push_back({port, 1'b0, sz});
    push_pay(d, nb(sz));
    @(negedge clk_sys);
    if (refuse) begin
      chk("slot full", stim_busy, 1);
      exp_q.push_back(tpsm_pkg::OVF_HDR);
      @(negedge clk_sys);
    end
    stim_wr = 1'b0;
  endtask

  // The offer stands until ready is seen, then drops after the taking edge.
  task automatic prof(logic [7:0] hd, logic [31:0] p);
    {prof_valid, prof_header, prof_payload} = {1'b1, hd, p};
    exp_q.push_back(hd);
    push_pay(p, nb(hd[1:0]));
    for (int i = 0; i < 50; i++) begin
      #1;
      if (prof_ready) break;
      @(negedge clk_sys);
    end
    @(negedge clk_sys);
    prof_valid = 1'b0;
  endtask

  initial begin
    {seed, n_errors, checked, stall, rst} = {32'd54, 32'd0, 32'd0, 1'b0, 1'b1};
    {stim_wr, prof_valid, data_trace_evt, counter_wrap, sync_req, gts_req} = '0;
    {pc_sample_enable, cycle_event_enable, lts_enable, stim_port, prof_header} = '0;
    {stim_size, stim_data, prof_payload, data_trace_val, pc_value, gts_value} = '0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    drain();
    chk("idle bytes", tpsm_sink_model_i.rx_q.size(), 0);
    push_sync();
    sync_req = 1'b1;
    @(negedge clk_sys);
    sync_req = 1'b0;
    compare_all();
    stall = 1'b1;  // The sink runs slow while packets queue up.
    for (int c = 1; c < 4; c++) stim(5'($random(seed)), 2'(c), $random(seed), 1'b0);
    stall = 1'b0;
    compare_all();
    stim(5'h03, 2'h3, $random(seed), 1'b1);
    compare_all();
    for (int c = 1; c < 4; c++) begin
      prof({6'($random(seed)), 2'(c)}, $random(seed));
      @(negedge clk_sys);
    end
    compare_all();
    data_trace_val = $random(seed);
    data_trace_evt = 1'b1;
    exp_q.push_back(8'h47);
    push_pay(data_trace_val, 4);
    @(negedge clk_sys);
    data_trace_evt = 1'b0;
    compare_all();
    push_sync();  // Sync wins over a stimulus write in the same cycle.
    sync_req = 1'b1;
    stim(5'h1F, 2'h2, $random(seed), 1'b0);
    sync_req = 1'b0;
    compare_all();
    gts_value = 28'($random(seed));
    gts_req = 1'b1;
    @(negedge clk_sys);
    gts_req = 1'b0;
    drain();
    pop_pkt(h, n);
    chk("timestamp header", h, tpsm_pkg::GTS_HDR);
    chk("timestamp payload", n >= 1, 1);
    if (n < 4) chk("last flag", pay[n-1][7], 0);
    for (int i = 0; i < n - 1; i++) chk("more flag", pay[i][7], 1);
    chk("leftover", tpsm_sink_model_i.rx_q.size(), 0);
    {counter_wrap, lts_enable} = 2'h3;
    @(negedge clk_sys);
    counter_wrap = 1'b0;
    drain();
    lts_enable = 1'b0;
    pop_pkt(h, n);
    chk("wrap category", h[1:0] != 2'h0, 1);
    pop_pkt(h, n);
    chk("lts header", h, tpsm_pkg::LTS_HDR);
    chk("lts length", n, 4);
    chk("wrap leftover", tpsm_sink_model_i.rx_q.size(), 0);
    for (int m = 0; m < 3; m++) begin  // Sample only, both enables, then event only.
      pc_value = $random(seed);
      {pc_sample_enable, cycle_event_enable} = {m != 2, m != 0};
      repeat (12) @(negedge clk_sys);
      {pc_sample_enable, cycle_event_enable} = 2'h0;
      drain();
      k = 0;
      while (tpsm_sink_model_i.rx_q.size() > 0) begin
        pop_pkt(h, n);
        k += (h != tpsm_pkg::OVF_HDR);
        if (h != tpsm_pkg::OVF_HDR)
          chk("timer header", h, m == 2 ? tpsm_pkg::EVT_CNT_HDR : tpsm_pkg::PC_SAMPLE_HDR);
        if (h == tpsm_pkg::PC_SAMPLE_HDR)
          for (int i = 0; i < 4; i++) chk("pc byte", pay[i], pc_value[8*i +: 8]);
      end
      chk("timer packets", k > 0, 1);
    end
    summarize();
  end
endmodule  // test_tpsm_merger

bind tpsm_merger tpsm_merger_props #(.PRESCALE(PRESCALE)) tpsm_merger_props_i (
  .clk_sys(clk_sys), .rst(rst), .stim_wr(stim_wr), .stim_busy(stim_busy),
  .prof_ready(prof_ready), .sync_req(sync_req), .pc_sample_enable(pc_sample_enable),
  .cycle_event_enable(cycle_event_enable), .out_valid(out_valid), .out_ready(out_ready),
  .out_byte(out_byte), .ser_bit(ser_bit), .ser_valid(ser_valid));
